// ### rtl/ddm_pkg.sv
package ddm_pkg;

   // Data bus shape
   localparam int DQ_W = 64;
   localparam int LANES = 8;
   localparam int LANE_W = 8;
   localparam int ADDR_W = 13;
   localparam int BA_W = 2;
   localparam int BANKS = 4;

   // Address bit that selects auto precharge or precharge-all
   localparam int A10_BIT = 10;
   // Column bit that picks the upper half of a row's share of a bank's storage; row bit 0 picks the bank half
   localparam int COL_SEL_BIT = 1;

   // Mode register select on the bank address during a load
   localparam logic [BA_W-1:0] MR_BASE = 2'h0;
   localparam logic [BA_W-1:0] MR_EXT = 2'h1;
   localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;

   // Burst and latency, in link clock cycles
   localparam int BURST = 2;
   localparam int RD_LAT = 2;
   localparam logic [2:0] RD_LOAD = 3'(RD_LAT + BURST - 1);
   localparam logic [2:0] WR_LOAD = 3'(BURST);
   localparam logic [2:0] BEAT0_CNT = 3'(BURST);
   localparam logic [2:0] PRE_CNT = 3'(BURST + 1);

   // Storage: {bank, row bit 0, column select, beat}
   localparam int MEM_AW = 5;
   localparam int MEM_DEPTH = 32;

   // Command code {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      OP_MRS = 4'b0000,
      OP_REF = 4'b0001,
      OP_PRE = 4'b0010,
      OP_ACT = 4'b0011,
      OP_WR = 4'b0100,
      OP_RD = 4'b0101,
      OP_BST = 4'b0110,
      OP_NOP = 4'b0111,
      OP_DESEL = 4'b1000
   } ddm_op_t;

   typedef enum logic [1:0] {
      PWR_ON = 2'b00,
      PWR_APD = 2'b01,
      PWR_PPD = 2'b10,
      PWR_SR = 2'b11
   } ddm_pwr_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } ddm_cmd_t;

   typedef struct packed {
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] a;
   } ddm_addr_t;

   typedef struct packed {
      ddm_pwr_t pwr;
      logic [BANKS-1:0] open;
      logic [ADDR_W-1:0] mode;
      logic [ADDR_W-1:0] emode;
   } ddm_stat_t;

   // Chip select high turns every code into a deselect
   function automatic ddm_op_t ddm_decode(input ddm_cmd_t c);
      if (c.cs_n) begin
         return OP_DESEL;
      end
      return ddm_op_t'({1'b0, c.ras_n, c.cas_n, c.we_n});
   endfunction : ddm_decode

endpackage : ddm_pkg

// ### rtl/ddm_sync.sv
`timescale 1ns/100ps
module ddm_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Level to bring across
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end

endmodule : ddm_sync

// ### rtl/ddm_rank.sv
`timescale 1ns/100ps
// Functional notes
// - Command from row, column, write strobes plus select
// - Sample control and address on CK rise
// - Output data and strobe timed to CK
// - CKE high keeps clock, buffers, drivers active
// - CKE low: idle gives PPD/SR, open APD
// - CKE sampled synchronously for power-down, SR entry
// - CKE acts asynchronously for SR exit, outputs off
// - Inputs ignored during power-down and self refresh
// - Select low enables decoder, high masks commands
// - Bank address picks the target bank
// - Row on activate; column, auto precharge on access
// - Precharge one bank, or all with A10
// - Mode load takes op-code from address
// - Bank address picks base or extended mode
// - Strobe edge-aligned on reads, centred on writes
// - Mask high blocks byte write; reads unaffected
module ddm_rank (
   // System clock side
   input wire logic clock_i,
   input wire logic rst_i,
   output ddm_pkg::ddm_stat_t status_o,
   output logic status_upd_o,
   // Link clock and command pins
   input wire logic ck_i,
   input wire logic cke_i,
   input ddm_pkg::ddm_cmd_t cmd_i,
   input ddm_pkg::ddm_addr_t addr_i,
   // Data, strobe and mask pins
   input wire logic [ddm_pkg::DQ_W-1:0] dq_i,
   output logic [ddm_pkg::DQ_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [ddm_pkg::LANES-1:0] dqs_i,
   output logic [ddm_pkg::LANES-1:0] dqs_o,
   output logic dqs_oe_o,
   input wire logic [ddm_pkg::LANES-1:0] dm_i
);
   import ddm_pkg::*;

   localparam int BASE_W = MEM_AW - 1;

   // Storage index: base location then beat number
   function automatic logic [MEM_AW-1:0] mem_idx(input logic [BASE_W-1:0] base,
                                                  input logic beat);
      return {base, beat};
   endfunction : mem_idx

   logic lrst;
   logic cke_prev_reg;
   ddm_pwr_t pwr_reg;
   logic sr_reg;
   logic [BANKS-1:0] open_reg;
   logic [ADDR_W-1:0] row_reg [BANKS];
   logic [ADDR_W-1:0] mode_reg;
   logic [ADDR_W-1:0] emode_reg;
   logic [DQ_W-1:0] mem_reg [MEM_DEPTH];
   logic [2:0] rd_cnt_reg;
   logic [2:0] wr_cnt_reg;
   logic [BASE_W-1:0] rd_base_reg;
   logic [BASE_W-1:0] wr_base_reg;
   ddm_stat_t snap_reg;
   logic req_reg;
   logic ack_s;
   logic req_s;
   logic ack_reg;
   ddm_op_t op;
   logic en_cmd;
   logic idle;
   logic sr_entry;
   logic pd_entry;
   logic rd_go;
   logic wr_go;
   logic rd_drive;
   logic rd_beat;
   logic wr_beat;
   logic [MEM_AW-1:0] wr_idx;
   logic [BASE_W-1:0] acc_base;
   logic [LANE_W-1:0] keep_byte;

   // Reset comes from the system domain; CK must run while it is held
   ddm_sync #(.W(1)) u_rst_sync (
      .clock_i(ck_i),
      .rst_i(1'b0),
      .d_i(rst_i),
      .q_o(lrst)
   );

   // Command decode and enables
   assign op = ddm_decode(cmd_i);
   // Decoder only listens with CKE high on two edges and no low-power state
   assign en_cmd = cke_i && cke_prev_reg && (pwr_reg == PWR_ON) && !sr_reg;
   assign idle = ~|open_reg;
   assign pd_entry = cke_prev_reg && !cke_i && (pwr_reg == PWR_ON) && !sr_reg;
   assign sr_entry = pd_entry && idle && (op == OP_REF);
   // Accesses need an open bank and a quiet data bus
   assign rd_go = en_cmd && (op == OP_RD) && open_reg[addr_i.ba] && (rd_cnt_reg == 3'h0) && (wr_cnt_reg == 3'h0);
   assign wr_go = en_cmd && (op == OP_WR) && open_reg[addr_i.ba] && (rd_cnt_reg == 3'h0) && (wr_cnt_reg == 3'h0);
   assign acc_base = {addr_i.ba, row_reg[addr_i.ba][0], addr_i.a[COL_SEL_BIT]};

   // Beat tracking for both directions
   assign rd_drive = (rd_cnt_reg != 3'h0) && (rd_cnt_reg <= BEAT0_CNT);
   assign rd_beat = rd_cnt_reg < BEAT0_CNT;
   assign wr_beat = wr_cnt_reg < BEAT0_CNT;
   assign wr_idx = mem_idx(wr_base_reg, wr_beat);
   assign keep_byte = mem_reg[wr_idx][LANE_W-1:0];

   // CKE history, registered on CK for synchronous entry and exit
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         cke_prev_reg <= 1'b0;
      end else begin
         cke_prev_reg <= cke_i;
      end
   end

   // Power-down kind follows the bank state at the CKE fall
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         pwr_reg <= PWR_ON;
      end else if (pd_entry) begin
         if (!idle) begin
            pwr_reg <= PWR_APD;
         end else if (op != OP_REF) begin
            pwr_reg <= PWR_PPD;
         end
      end else if (!cke_prev_reg && cke_i) begin
         pwr_reg <= PWR_ON;
      end
   end

   // Self refresh: entered on CK, left the moment CKE rises since CK may be stopped
   always_ff @(posedge ck_i or posedge cke_i) begin
      if (cke_i) begin
         sr_reg <= 1'b0;
      end else if (lrst) begin
         sr_reg <= 1'b0;
      end else if (sr_entry) begin
         sr_reg <= 1'b1;
      end
   end

   // Bank open state
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         open_reg <= '0;
      end else if (en_cmd) begin
         case (op)
            OP_ACT: begin
               open_reg[addr_i.ba] <= 1'b1;
            end
            OP_PRE: begin
               if (addr_i.a[A10_BIT]) begin
                  open_reg <= '0;
               end else begin
                  open_reg[addr_i.ba] <= 1'b0;
               end
            end
            OP_RD, OP_WR: begin
               // Auto precharge closes the bank at issue; data still uses the captured base
               if ((rd_go || wr_go) && addr_i.a[A10_BIT]) begin
                  open_reg[addr_i.ba] <= 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Row address captured on activate
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         for (int b = 0; b < BANKS; b++) begin
            row_reg[b] <= '0;
         end
      end else if (en_cmd && (op == OP_ACT)) begin
         row_reg[addr_i.ba] <= addr_i.a;
      end
   end

   // Mode registers; unknown bank codes are dropped
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         mode_reg <= MODE_RST;
         emode_reg <= MODE_RST;
      end else if (en_cmd && (op == OP_MRS)) begin
         if (addr_i.ba == MR_BASE) begin
            mode_reg <= addr_i.a;
         end else if (addr_i.ba == MR_EXT) begin
            emode_reg <= addr_i.a;
         end
      end
   end

   // Read burst counter; a burst relies on CKE staying high
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         rd_cnt_reg <= 3'h0;
         rd_base_reg <= '0;
      end else if (rd_go) begin
         rd_cnt_reg <= RD_LOAD;
         rd_base_reg <= acc_base;
      end else if (rd_cnt_reg != 3'h0) begin
         rd_cnt_reg <= rd_cnt_reg - 3'h1;
      end
   end

   // Read data and strobe change on the same CK edge
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         dq_o <= '0;
         dqs_o <= '0;
      end else begin
         if (rd_drive) begin
            dq_o <= mem_reg[mem_idx(rd_base_reg, rd_beat)];
         end
         dqs_o <= {LANES{rd_drive && !rd_beat}};
      end
   end

   // Drivers drop at once when CKE falls, without waiting for CK
   always_ff @(posedge ck_i or negedge cke_i) begin
      if (!cke_i) begin
         dq_oe_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end else if (lrst) begin
         dq_oe_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end else begin
         dq_oe_o <= rd_drive;
         dqs_oe_o <= rd_drive || (rd_cnt_reg == PRE_CNT);
      end
   end

   // Write burst counter
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         wr_cnt_reg <= 3'h0;
         wr_base_reg <= '0;
      end else if (wr_go) begin
         wr_cnt_reg <= WR_LOAD;
         wr_base_reg <= acc_base;
      end else if (wr_cnt_reg != 3'h0) begin
         wr_cnt_reg <= wr_cnt_reg - 3'h1;
      end
   end

   // Byte lanes land only when unmasked and the strobe shows the expected phase
   always_ff @(posedge ck_i) begin
      if (wr_cnt_reg != 3'h0) begin
         for (int k = 0; k < LANES; k++) begin
            if (!dm_i[k] && (dqs_i[k] == !wr_beat)) begin
               mem_reg[wr_idx][k*LANE_W +: LANE_W] <= dq_i[k*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Status snapshot handshake, link side
   ddm_sync #(.W(1)) u_ack_sync (
      .clock_i(ck_i),
      .rst_i(lrst),
      .d_i(ack_reg),
      .q_o(ack_s)
   );

   // Snapshot stays frozen while the request is up, so the word is stable to the reader
   always_ff @(posedge ck_i) begin
      if (lrst) begin
         req_reg <= 1'b0;
         snap_reg <= '0;
      end else if (!req_reg && !ack_s) begin
         snap_reg.pwr <= sr_reg ? PWR_SR : pwr_reg;
         snap_reg.open <= open_reg;
         snap_reg.mode <= mode_reg;
         snap_reg.emode <= emode_reg;
         req_reg <= 1'b1;
      end else if (req_reg && ack_s) begin
         req_reg <= 1'b0;
      end
   end

   // Status snapshot handshake, system side
   ddm_sync #(.W(1)) u_req_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .d_i(req_reg),
      .q_o(req_s)
   );

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         status_o <= '0;
         status_upd_o <= 1'b0;
      end else begin
         ack_reg <= req_s;
         status_upd_o <= req_s && !ack_reg;
         if (req_s && !ack_reg) begin
            status_o <= snap_reg;
         end
      end
   end

   // Checks on the link side
   default clocking cb @(posedge ck_i);
   endclocking
   default disable iff (lrst);

   a_desel_ignored: assert property (cmd_i.cs_n |=> $stable(open_reg) && $stable(mode_reg))
      else $error("deselected command changed state");

   a_act_opens: assert property ((en_cmd && op == OP_ACT) |=> open_reg[$past(addr_i.ba)])
      else $error("activate did not open the bank");

   a_act_row: assert property ((en_cmd && op == OP_ACT) |=> row_reg[$past(addr_i.ba)] == $past(addr_i.a))
      else $error("activate row not captured");

   a_pre_all: assert property ((en_cmd && op == OP_PRE && addr_i.a[A10_BIT]) |=> open_reg == '0)
      else $error("precharge all left a bank open");

   a_pre_one: assert property ((en_cmd && op == OP_PRE && !addr_i.a[A10_BIT]) |=> !open_reg[$past(addr_i.ba)])
      else $error("single precharge left bank open");

   a_mrs_base: assert property ((en_cmd && op == OP_MRS && addr_i.ba == MR_BASE)
      |=> mode_reg == $past(addr_i.a) && $stable(emode_reg))
      else $error("base mode register load wrong");

   a_mrs_ext: assert property ((en_cmd && op == OP_MRS && addr_i.ba == MR_EXT)
      |=> emode_reg == $past(addr_i.a) && $stable(mode_reg))
      else $error("extended mode register load wrong");

   a_pd_active: assert property ((pd_entry && !idle) |=> pwr_reg == PWR_APD)
      else $error("open bank did not give active power-down");

   a_sr_entry: assert property (sr_entry |=> sr_reg || cke_i)
      else $error("self refresh not entered");

   a_rd_strobe: assert property ((rd_go ##1 cke_i [*3]) |-> (dq_oe_o && dqs_o == '1)
      ##1 (dq_oe_o && dqs_o == '0))
      else $error("read strobe not aligned with data");

   a_oe_off: assert property (!cke_i |-> !dq_oe_o && !dqs_oe_o)
      else $error("drivers on with clock enable low");

   a_mask_keep: assert property ((wr_cnt_reg != 3'h0 && dm_i[0])
      |=> mem_reg[$past(wr_idx)][LANE_W-1:0] == $past(keep_byte))
      else $error("masked byte was written");

endmodule : ddm_rank

// ### verif/ddm_host.sv
`timescale 1ns/100ps
// Host controller model driving one rank of the module
module ddm_host
   import ddm_pkg::*;
(
   // Link clock from the bench
   input wire logic ck_i,
   // Pins toward the rank
   output logic cke_o,
   output ddm_pkg::ddm_cmd_t cmd_o,
   output ddm_pkg::ddm_addr_t addr_o,
   output logic [ddm_pkg::DQ_W-1:0] dq_o,
   output logic [ddm_pkg::LANES-1:0] dqs_o,
   output logic [ddm_pkg::LANES-1:0] dm_o
);
   // Idle pins at time zero
   initial begin
      cke_o = 1'b1;
      cmd_o = ddm_cmd_t'(OP_NOP);
      addr_o = '0;
      dq_o = '0;
      dqs_o = '0;
      dm_o = '0;
   end

   // One command per call, this rank only
   task automatic issue(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
      @(posedge ck_i);
      cmd_o <= ddm_cmd_t'(c);
      addr_o <= {ba, a};
      @(posedge ck_i);
      cmd_o <= ddm_cmd_t'(OP_NOP);
      addr_o <= ~{ba, a}; // Released address must not look valid
   endtask : issue

   // CKE left high through the whole burst
   task automatic write(input logic [1:0] ba, input logic [12:0] a, input logic [63:0] d0, input logic [63:0] d1,
                        input logic [7:0] m0, input logic [7:0] m1);
      issue(OP_WR, ba, a);
      dq_o <= d0;
      dqs_o <= 8'hff; // Strobe level centred in each beat
      dm_o <= m0;
      @(posedge ck_i);
      dq_o <= d1;
      dqs_o <= 8'h00;
      dm_o <= m1;
      @(posedge ck_i);
      dq_o <= ~d1;
      dqs_o <= 8'hff;
      dm_o <= ~m1;
      @(posedge ck_i);
   endtask : write

   // Mask held high so a read would show any mask leak
   task automatic read(input logic [1:0] ba, input logic [12:0] a);
      issue(OP_RD, ba, a);
      dm_o <= 8'hff;
      repeat (3) @(posedge ck_i);
   endtask : read

   // CKE falls together with the given command
   task automatic sleep(input logic [3:0] c);
      @(posedge ck_i);
      cmd_o <= ddm_cmd_t'(c);
      cke_o <= 1'b0;
      @(posedge ck_i);
      cmd_o <= ddm_cmd_t'(OP_NOP);
   endtask : sleep

   // Wake on an edge, or off the clock for self refresh exit
   task automatic wake(input logic async_exit);
      if (async_exit) begin
         @(negedge ck_i);
         #2;
         cke_o <= 1'b1;
      end else begin
         @(posedge ck_i);
         cke_o <= 1'b1;
      end
      repeat (2) @(posedge ck_i);
   endtask : wake
endmodule : ddm_host

// ### verif/ddm_rank_bench.sv
`timescale 1ns/100ps
module ddm_rank_bench;
   import ddm_pkg::*;
   logic clock_i, rst_i, ck, cke, dq_oe, dqs_oe, upd;
   ddm_stat_t status;
   ddm_cmd_t cmd;
   ddm_addr_t addr;
   logic [63:0] dq_w, dq_r;
   logic [7:0] dqs_w, dqs_r, dm;
   logic [63:0] mem [32];
   logic [71:0] exp_q [$];
   logic [12:0] mode_e, emode_e, c2, c0;
   logic [3:0] open_e, row0;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   integer seed = 32'ha3464878;

   // System clock and an unrelated link clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial begin
      ck = 1'b0;
      #1.3;
      forever #7.5 ck = ~ck;
   end

   ddm_rank u_ddm_rank (.clock_i(clock_i), .rst_i(rst_i), .status_o(status), .status_upd_o(upd), .ck_i(ck),
      .cke_i(cke), .cmd_i(cmd), .addr_i(addr), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe), .dqs_i(dqs_w),
      .dqs_o(dqs_r), .dqs_oe_o(dqs_oe), .dm_i(dm));
   ddm_host u_ddm_host (.ck_i(ck), .cke_o(cke), .cmd_o(cmd), .addr_o(addr), .dq_o(dq_w), .dqs_o(dqs_w),
      .dm_o(dm));

   task automatic stop_test;
      n_errors += exp_q.size(); // Unseen read beats count as misses
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Status needs time to cross; the third snapshot after a change is surely fresh
   task automatic stat(input ddm_pwr_t p);
      int seen;
      seen = 0;
      while (seen < 3) begin
         @(posedge clock_i);
         if (upd === 1'b1) begin
            seen++;
         end
      end
      // Read half a cycle on, while the word stands and after the pulse has dropped
      @(negedge clock_i);
      chk(72'(status), 72'({p, open_e, mode_e, emode_e}));
      chk(72'(upd), 72'h0);
   endtask : stat

   task automatic act(input logic [1:0] ba, input logic [12:0] r);
      row0[ba] = r[0];
      open_e[ba] = 1'b1;
      u_ddm_host.issue(OP_ACT, ba, r);
   endtask : act

   // Expected storage follows the mask per lane and beat
   task automatic wr(input logic [1:0] ba, input logic [12:0] a, input logic [7:0] m0, input logic [7:0] m1);
      logic [63:0] d [2];
      d[0] = {$random(seed), $random(seed)};
      d[1] = {$random(seed), $random(seed)};
      for (int b = 0; b < 2; b++) begin
         for (int k = 0; k < 8; k++) begin
            if (!(b == 0 ? m0[k] : m1[k])) begin
               mem[{ba, row0[ba], a[1], b[0]}][k*8+:8] = d[b][k*8+:8];
            end
         end
      end
      u_ddm_host.write(ba, a, d[0], d[1], m0, m1);
   endtask : wr

   task automatic rd(input logic [1:0] ba, input logic [12:0] a);
      exp_q.push_back({8'hff, mem[{ba, row0[ba], a[1], 1'b0}]});
      exp_q.push_back({8'h00, mem[{ba, row0[ba], a[1], 1'b1}]});
      u_ddm_host.read(ba, a);
   endtask : rd

   // Each driven read beat takes the oldest note; none left means a stray read
   // An unknown enable counts as a beat too, so it cannot slip past
   always @(negedge ck) begin
      if (rst_i === 1'b0 && dq_oe !== 1'b0) begin
         chk({dqs_r, dq_r}, exp_q.size() > 0 ? exp_q.pop_front() : 72'hx);
         chk(72'({dq_oe, dqs_oe}), 72'h3);
      end
   end

   // Hang guard, far above the expected run length
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         stop_test;
      end
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      open_e = '0;
      row0 = '0;
      mode_e = MODE_RST;
      emode_e = MODE_RST;
      c2 = 13'h0002 | 13'($random(seed) & 32'h1f8);
      c0 = 13'($random(seed) & 32'h1f8);
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ck);
      stat(PWR_ON);
      mode_e = 13'($random(seed));
      emode_e = 13'($random(seed));
      u_ddm_host.issue(OP_MRS, MR_BASE, mode_e);
      u_ddm_host.issue(OP_MRS, MR_EXT, emode_e);
      u_ddm_host.issue(OP_MRS, 2'h2, ~mode_e);
      u_ddm_host.issue(OP_DESEL, MR_BASE, ~emode_e);
      stat(PWR_ON);
      act(2'h0, 13'($random(seed)));
      act(2'h2, 13'($random(seed)));
      stat(PWR_ON);
      wr(2'h2, c2, 8'h00, 8'h00);
      wr(2'h2, c2, 8'($random(seed)), 8'hff);
      wr(2'h0, c0, 8'h00, 8'h00);
      rd(2'h2, c2);
      rd(2'h0, c0);
      u_ddm_host.issue(4'b1101, 2'h2, c2);
      repeat (4) @(posedge ck);
      u_ddm_host.issue(OP_PRE, 2'h0, 13'h0000);
      open_e[0] = 1'b0;
      stat(PWR_ON);
      u_ddm_host.sleep(OP_NOP);
      stat(PWR_APD);
      u_ddm_host.wake(1'b0);
      stat(PWR_ON);
      rd(2'h2, c2 | 13'h0400);
      open_e[2] = 1'b0;
      stat(PWR_ON);
      u_ddm_host.issue(OP_RD, 2'h2, c2);
      repeat (4) @(posedge ck);
      act(2'h1, 13'($random(seed)));
      act(2'h3, 13'($random(seed)));
      u_ddm_host.issue(OP_PRE, 2'h3, 13'h0400);
      open_e = '0;
      stat(PWR_ON);
      u_ddm_host.sleep(OP_NOP);
      u_ddm_host.issue(OP_ACT, 2'h1, 13'h0000);
      stat(PWR_PPD);
      u_ddm_host.wake(1'b0);
      stat(PWR_ON);
      u_ddm_host.sleep(OP_REF);
      stat(PWR_SR);
      u_ddm_host.wake(1'b1);
      stat(PWR_ON);
      stop_test;
   end
endmodule : ddm_rank_bench
